// ==== src/old_consts.svh ====
// Constants for the octal low-side driver serial control block
`ifndef OLD_CONSTS_SVH
`define OLD_CONSTS_SVH
// Overview of operation
// R1: Latch control word only if frame had a whole multiple of eight clocks.
// R2: Diagnostic conditions on outputs one and two must persist 15..50 us.
// R3: Eight low-side outputs, each commanded by one serial control bit.
// R4: Outputs one and two switch from parallel inputs or serial bits.
// R5: Output commanded on flags on-state fault: overcurrent, or thermal on 7, 8.
// R6: Output commanded off flags open load or short to ground.
// R7: Status of every output is read out over the serial interface.
// R8: Internal reset is external clear or undervoltage reset.
// R9: Data sampled on falling clock while selected; rising select latches it.
// R10: Falling select loads status; shifted out on each rising clock.
// R11: Outputs 1, 2 on if parallel low or bit one; others follow bit.
// R12: Fault latches of outputs one and two clear while select is low.
// R13: Internal reset clears all control latches, keeping outputs off.
// R14: Serial data output floats while select is high.
`define OLD_NCH          8
`define OLD_CTRL_RST     8'h00
`define OLD_CLK_MHZ      40
`define OLD_FILT_MIN_US  15
`define OLD_FILT_MAX_US  50
// Least filter time rounded up to whole cycles: 600 cycles at 40 MHz
`define OLD_FILT_CYC     ((`OLD_FILT_MIN_US * 1000 + (1000 / `OLD_CLK_MHZ) - 1) / (1000 / `OLD_CLK_MHZ))
`define OLD_FILT_W       10
`endif

// ==== src/old_pkg.sv ====
// Types for the octal low-side driver serial control block
package old_pkg;
  typedef logic [7:0] old_byte_t;
  typedef struct packed {
    old_byte_t overload;   // On-state fault per output (high = fault)
    old_byte_t low_volt;   // Output voltage below diagnostic threshold
  } old_sense_s;
  typedef enum logic [0:0] {OLD_IDLE, OLD_FRAME} old_frame_e;
endpackage : old_pkg

// ==== src/old_ctrl.sv ====
// Serial control, diagnostics and reset logic of the octal low-side driver
`timescale 1ns/100ps
`default_nettype none
`include "old_consts.svh"
module old_ctrl
  import old_pkg::*;
#(
  parameter int FILT_CYC = `OLD_FILT_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sclk_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       sdi_i,
  input  wire logic       external_clear_n_i,
  input  wire logic       uv_reset_i,
  input  wire logic       parallel_drive_low_ch1_i,
  input  wire logic       parallel_drive_low_ch2_i,
  input  wire old_sense_s sense_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  output old_byte_t       drive_o,
  output logic            int_rst_o
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock
  logic [1:0] rst_sync_ff;
  logic [1:0] uv_sync_ff;
  logic [1:0] par1_sync_ff;
  logic [1:0] par2_sync_ff;
  old_sense_s sense_m_ff;
  old_sense_s sense_ff;
  logic [1:0] cs_sync_ff;
  logic       cs_d_ff;
  logic       frame_end;

  // Reset pin is active low; the internal chain runs active high
  always_ff @(posedge mclk_i) begin
    rst_sync_ff <= {rst_sync_ff[0], ~external_clear_n_i};
  end

  always_ff @(posedge mclk_i) begin
    uv_sync_ff <= {uv_sync_ff[0], uv_reset_i};
  end

  // Parallel lines may carry fast PWM; two stages trade 50 ns latency for safety
  always_ff @(posedge mclk_i) begin
    par1_sync_ff <= {par1_sync_ff[0], parallel_drive_low_ch1_i};
  end

  always_ff @(posedge mclk_i) begin
    par2_sync_ff <= {par2_sync_ff[0], parallel_drive_low_ch2_i};
  end

  always_ff @(posedge mclk_i) begin
    cs_sync_ff <= {cs_sync_ff[0], chip_select_n_i};
  end

  // Sense levels come from comparators, asynchronous to this clock
  always_ff @(posedge mclk_i) begin
    sense_m_ff <= sense_i;
    sense_ff   <= sense_m_ff;
  end

  always_ff @(posedge mclk_i) begin
    cs_d_ff <= cs_sync_ff[1];
  end

  // One-cycle strobe when the synchronised select is first seen high
  assign frame_end = cs_sync_ff[1] & ~cs_d_ff;

  logic int_rst;
  assign int_rst = sys_rst_i | rst_sync_ff[1] | uv_sync_ff[1];  // R8
  always_ff @(posedge mclk_i) begin
    int_rst_o <= int_rst;
  end

  ////////////////////////////////////////////////////////////////////////
  // Link side: runs on the host serial clock; count and output are held clear while deselected
  old_byte_t shift_ff;
  logic [2:0] bitcnt_ff;
  logic       loaded_ff;
  old_byte_t  stat_hold_ff;

  // Falling sclk samples input; status is parallel-loaded at first falling edge of frame
  // Select high clears the count, so a cut frame never leaves a stale count
  always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      bitcnt_ff <= 3'h0;
      loaded_ff <= 1'b0;
    end else begin
      bitcnt_ff <= bitcnt_ff + 3'h1;  // R1
      loaded_ff <= 1'b1;
    end
  end

  always_ff @(negedge sclk_i) begin
    if (!loaded_ff)
      shift_ff <= {stat_hold_ff[6:0], sdi_i};  // R10
    else
      shift_ff <= {shift_ff[6:0], sdi_i};  // R9
  end

  // Each rising clock presents one bit: status most significant first, then the bits shifted in
  // Limitation: the line shows low from select fall until the first rising clock
  always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i)
      sdo_o <= 1'b0;
    else
      sdo_o <= loaded_ff ? shift_ff[7] : stat_hold_ff[7];  // R10
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossing: frame word is stable once select is high, sampled then
  old_byte_t word_m_ff, word_ff;
  logic [1:0] cnt_m_ff;
  logic       bit_ok_ff;
  always_ff @(posedge mclk_i) begin
    word_m_ff <= shift_ff;
    word_ff   <= word_m_ff;
  end

  // Whole-byte flag is taken before select rise clears the link counter
  always_ff @(posedge mclk_i) begin
    cnt_m_ff  <= {cnt_m_ff[0], (bitcnt_ff == 3'h0) & loaded_ff};
    bit_ok_ff <= cnt_m_ff[1];
  end
  // Link flops settle well before the select rise reaches cs_sync_ff[1]

  old_byte_t ctrl_ff;
  always_ff @(posedge mclk_i) begin
    if (int_rst)
      ctrl_ff <= `OLD_CTRL_RST;  // R13
    else if (frame_end && bit_ok_ff)
      ctrl_ff <= word_ff;  // R1 R9 R3
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive and diagnostics
  old_byte_t on_cmd;
  old_byte_t stat_raw;

  // Outputs one and two: either control path can switch them on
  always_comb begin
    on_cmd    = ctrl_ff;  // R3 R11
    on_cmd[0] = ctrl_ff[0] | ~par1_sync_ff[1];  // R4 R11
    on_cmd[1] = ctrl_ff[1] | ~par2_sync_ff[1];  // R4 R11
  end

  // Status bit is high for correct operation and low for a fault
  always_comb begin
    stat_raw = '0;
    for (int i = 0; i < `OLD_NCH; i++) begin
      if (on_cmd[i])
        stat_raw[i] = ~sense_ff.overload[i];  // R5
      else
        stat_raw[i] = ~sense_ff.low_volt[i];  // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic filter and fault latches of outputs one and two
  logic [`OLD_FILT_W-1:0] filt_cnt_ff [2];
  logic [1:0]             filt_st_ff;
  logic [1:0]             fault_ff;

  for (genvar g = 0; g < 2; g++) begin : g_filt
    // Any return to the filtered level restarts the count, so glitches die
    // Limitation: FILT_CYC must fit the counter width
    always_ff @(posedge mclk_i) begin
      if (int_rst || stat_raw[g] == filt_st_ff[g])
        filt_cnt_ff[g] <= '0;
      else if (filt_cnt_ff[g] == `OLD_FILT_W'(FILT_CYC - 1))
        filt_cnt_ff[g] <= '0;
      else
        filt_cnt_ff[g] <= filt_cnt_ff[g] + `OLD_FILT_W'(1);
    end

    always_ff @(posedge mclk_i) begin
      if (int_rst)
        filt_st_ff[g] <= 1'b1;
      else if (stat_raw[g] != filt_st_ff[g] &&
               filt_cnt_ff[g] == `OLD_FILT_W'(FILT_CYC - 1))
        filt_st_ff[g] <= stat_raw[g];  // R2
    end

    always_ff @(posedge mclk_i) begin
      if (int_rst)
        fault_ff[g] <= 1'b0;
      else if (!filt_st_ff[g])
        fault_ff[g] <= 1'b1;  // Set wins over the clear
      else if (!cs_sync_ff[1])
        fault_ff[g] <= 1'b0;  // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs and status capture
  old_byte_t stat_ff;

  // Drivers go off in the same cycle that the internal reset is reported
  always_ff @(posedge mclk_i) begin
    drive_o <= int_rst ? `OLD_CTRL_RST : on_cmd;  // R13
  end

  always_ff @(posedge mclk_i) begin
    stat_ff <= {stat_raw[7:2], ~fault_ff};  // R7
  end

  // Status hold freezes during a frame so the link sees a stable word
  always_ff @(posedge mclk_i) begin
    if (cs_sync_ff[1])
      stat_hold_ff <= stat_ff;
  end

  // Enable follows the synchronised select, three cycles or 75 ns behind
  always_ff @(posedge mclk_i) begin
    sdo_oe_n_o <= cs_sync_ff[1];  // R14
  end
endmodule : old_ctrl
`default_nettype wire

// ==== verif/old_ctrl_chk.sv ====
// Port checker
`timescale 1ns/100ps
`default_nettype none
module old_chk
  import old_pkg::*;
(
  input wire logic      mclk_i,
  input wire logic      sys_rst_i,
  input wire logic      chip_select_n_i,
  input wire logic      external_clear_n_i,
  input wire logic      uv_reset_i,
  input wire logic      parallel_drive_low_ch1_i,
  input wire logic      parallel_drive_low_ch2_i,
  input wire logic      sdo_oe_n_o,
  input wire logic      int_rst_o,
  input wire old_byte_t drive_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_ext_rst: assert property ((!external_clear_n_i)[*4] |-> int_rst_o) else $error("r");
  a_uv_rst: assert property (uv_reset_i[*4] |-> int_rst_o) else $error("u");
  a_rst_free: assert property ((external_clear_n_i && !uv_reset_i)[*5] |-> !int_rst_o)
    else $error("f");
  a_rst_off: assert property (int_rst_o[*2] |-> drive_o == 8'h00) else $error("o");
  a_rst_hold: assert property ($fell(int_rst_o) |-> drive_o[7:2] == 6'h00) else $error("h");
  a_sdo_drive: assert property ((!chip_select_n_i)[*4] |-> !sdo_oe_n_o) else $error("e");
  a_par_two: assert property ((!parallel_drive_low_ch2_i && !int_rst_o)[*4] |-> drive_o[1])
    else $error("q");
  a_sdo_float: assert property (chip_select_n_i[*8] |-> sdo_oe_n_o) else $error("s");
  a_drive_hold: assert property (
    (chip_select_n_i && !int_rst_o)[*8] |-> $stable(drive_o[7:2])) else $error("d");
  a_par_one: assert property ((!parallel_drive_low_ch1_i && !int_rst_o)[*4] |-> drive_o[0])
    else $error("p");
endmodule : old_chk
bind old_ctrl old_chk u_chk (.*);
`default_nettype wire

// ==== verif/old_host.sv ====
// Host model
`timescale 1ns/100ps
`default_nettype none
module old_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    sdi_o  = 1'h0;
  end
  // Status is taken at the falling clock, half a period after it was launched
  task automatic tx(input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0000;
    cs_n_o = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      #(i == n - 1 ? 100 : 80) sclk_o = 1'h1;
      sdi_o = d[i];
      #80 sclk_o = 1'h0;
      q[i] = sdo_i;
    end
    #150 cs_n_o = 1'h1;
    sdi_o = ~sdi_o;
    #300;
  endtask : tx
endmodule : old_host
`default_nettype wire

// ==== verif/octal_lowside_driver_serial_control_test.sv ====
// Bench
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: compare mismatch", $time); end end
module octal_lowside_driver_serial_control_test;
  import old_pkg::*;
  logic       mclk_i = 1'h0, sys_rst_i = 1'h1, external_clear_n_i = 1'h1, uv_reset_i = 1'h0;
  logic       p1_n = 1'h1, p2_n = 1'h1, sclk_i, chip_select_n_i, sdi_i, int_rst_o;
  logic       sdo_o, sdo_oe_n_o, sdo_line;
  old_sense_s sense = '0;
  logic [7:0] drive_o;
  int         fail_count, num_checks;
  // An undriven line shows the inverse of sdo_o, which select high clears, so it reads high
  assign sdo_line = sdo_oe_n_o ? ~sdo_o : sdo_o;
  old_host u_host (.sclk_o(sclk_i), .cs_n_o(chip_select_n_i), .sdi_o(sdi_i), .sdo_i(sdo_line));
  old_ctrl #(.FILT_CYC(4)) u_dut (
    .mclk_i                   (mclk_i),
    .sys_rst_i                (sys_rst_i),
    .sclk_i                   (sclk_i),
    .chip_select_n_i          (chip_select_n_i),
    .sdi_i                    (sdi_i),
    .external_clear_n_i       (external_clear_n_i),
    .uv_reset_i               (uv_reset_i),
    .parallel_drive_low_ch1_i (p1_n),
    .parallel_drive_low_ch2_i (p2_n),
    .sense_i                  (sense),
    .sdo_o                    (sdo_o),
    .sdo_oe_n_o               (sdo_oe_n_o),
    .drive_o                  (drive_o),
    .int_rst_o                (int_rst_o)
  );
  initial forever #12.5 mclk_i = ~mclk_i;
  task automatic t_len;
    logic [15:0] q;
    repeat (4) @(negedge mclk_i);
    `CHK(sdo_oe_n_o, 1'b1)
    u_host.tx(16'ha5, 8, q);
    `CHK(drive_o, 8'ha5)
    `CHK(q, 16'h00ff)
    u_host.tx(16'h3c, 7, q);
    `CHK(drive_o, 8'ha5)
    `CHK(q, 16'h007f)
    u_host.tx(16'h3c5a, 16, q);
    `CHK(drive_o, 8'h5a)
    `CHK(q, 16'hff3c)
  endtask : t_len
  task automatic t_diag;
    logic [15:0] q;
    u_host.tx(16'h04, 8, q);
    `CHK(drive_o, 8'h04)
    @(negedge mclk_i) sense = 16'h0481;
    repeat (20) @(negedge mclk_i);
    u_host.tx(16'h04, 8, q);
    `CHK(q[2], 1'b0)
    `CHK(q[7], 1'b0)
    `CHK(q, 16'h007a)
    @(negedge mclk_i) sense = 16'h0002;
    repeat (2) @(negedge mclk_i);
    sense = '0;
    repeat (20) @(negedge mclk_i);
    u_host.tx(16'h04, 8, q);
    `CHK(q[1], 1'b1)
    `CHK(q, 16'h00fe)
    u_host.tx(16'h04, 8, q);
    `CHK(q, 16'h00ff)
  endtask : t_diag
  task automatic t_pins;
    logic [15:0] q;
    @(negedge mclk_i) {p1_n, p2_n} = 2'h0;
    u_host.tx(16'hf0, 8, q);
    `CHK(drive_o, 8'hf3)
    @(negedge mclk_i) {p1_n, p2_n, external_clear_n_i} = 3'h6;
    repeat (8) @(negedge mclk_i);
    `CHK({int_rst_o, drive_o}, 9'h100)
    {external_clear_n_i, uv_reset_i} = 2'h3;
    repeat (8) @(negedge mclk_i);
    `CHK(int_rst_o, 1'b1)
    uv_reset_i = 1'h0;
    repeat (8) @(negedge mclk_i);
    `CHK({int_rst_o, drive_o}, 9'h000)
    u_host.tx(16'h81, 8, q);
    `CHK(drive_o, 8'h81)
    `CHK(q, 16'h00ff)
  endtask : t_pins
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #200 sys_rst_i = 1'h0;
    t_len();
    t_diag();
    t_pins();
    end_sim();
  end
  initial #100000 begin
    fail_count++;
    end_sim();
  end
endmodule : octal_lowside_driver_serial_control_test
`default_nettype wire
